// file: rtl/rpp_pkg.sv
// Package: constants and types for the registered PROM program and read block
`default_nettype none
package rpp_pkg;
  localparam int          ADDR_W        = 9;
  localparam int          DATA_W        = 8;
  localparam int          DEPTH         = 512;
  localparam logic [8:0]  LAST_ADDR     = 9'h1ff;
  localparam logic [7:0]  ALL_ONES      = 8'hff;
  localparam logic [7:0]  ALL_ZEROS     = 8'h00;
  localparam int          SYNC_STAGES   = 3;
  // Shortest program pulse the cell accepts, and the cycles it needs at 100 MHz
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MIN_PULSE_US  = 100;
  localparam int          MIN_PULSE_CYC = (MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RPP_MODE_READ    = 3'b000,
    RPP_MODE_INHIBIT = 3'b001,
    RPP_MODE_PROGRAM = 3'b010,
    RPP_MODE_VERIFY  = 3'b011,
    RPP_MODE_BLANK1  = 3'b100,
    RPP_MODE_BLANK0  = 3'b101
  } rpp_mode_type;
endpackage : rpp_pkg
`default_nettype wire

// file: rtl/rpp_sync.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree
`default_nettype none
module rpp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } rpp_sync_state_type;

  rpp_sync_state_type st_r;
  rpp_sync_state_type st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;
endmodule : rpp_sync
`default_nettype wire

// file: rtl/rpp_prom.sv
// Registered 512x8 PROM core: clocked read, supervoltage programming, verify and blank check
`default_nettype none
module rpp_prom #(
  parameter int ADDR_W = rpp_pkg::ADDR_W,
  parameter int DATA_W = rpp_pkg::DATA_W,
  parameter int DEPTH  = rpp_pkg::DEPTH
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              register_clock_i,
  input  wire logic              sync_output_enable_n_i,
  input  wire logic              async_output_enable_n_i,
  input  wire logic              supervoltage_i,
  input  wire logic              blank_check_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [DATA_W-1:0] data_oe_n_o,
  output logic                   unknown_o,
  output logic      [2:0]        mode_o
);
  localparam int PIN_W = ADDR_W + DATA_W + 5;
  localparam int CNT_W = $clog2(rpp_pkg::MIN_PULSE_CYC + 1);
  localparam int LAST_PULSE = rpp_pkg::MIN_PULSE_CYC - 1;

  typedef struct packed {
    logic                     clk_d;
    logic                     outen;
    logic [DATA_W-1:0]        outreg;
    logic                     outreg_unk;
    logic [CNT_W-1:0]         pulse_cnt;
    logic [DATA_W-1:0]        dout;
    logic [DATA_W-1:0]        doe_n;
    logic                     unk;
    rpp_pkg::rpp_mode_type    mode;
  } rpp_state_type;

  // Cell array: a written flag per byte stands for the differential cell leaving its erased state
  logic [DATA_W-1:0] cell_data_r [DEPTH];
  logic [DEPTH-1:0]  cell_prog_r;

  logic [PIN_W-1:0]  pins_s;
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] d_s;
  logic              cp_s;
  logic              es_n_s;
  logic              e_n_s;
  logic              vpp_s;
  logic              blank_s;

  rpp_state_type st_r;
  rpp_state_type st_nxt;
  logic          commit;

  rpp_sync #(
    .W (PIN_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({addr_i, data_i, register_clock_i, sync_output_enable_n_i,
                 async_output_enable_n_i, supervoltage_i, blank_check_i}),
    .level_o   (pins_s)
  );

  assign {a_s, d_s, cp_s, es_n_s, e_n_s, vpp_s, blank_s} = pins_s;

  function automatic rpp_pkg::rpp_mode_type decode_mode(input logic vpp, input logic blank,
                                                        input logic pgm_n, input logic verify_strobe);
    if (blank) begin
      return verify_strobe ? rpp_pkg::RPP_MODE_BLANK0 : rpp_pkg::RPP_MODE_BLANK1;
    end else if (!vpp) begin
      return rpp_pkg::RPP_MODE_READ;
    end else if (!pgm_n && verify_strobe) begin
      return rpp_pkg::RPP_MODE_PROGRAM;
    end else if (pgm_n && !verify_strobe) begin
      return rpp_pkg::RPP_MODE_VERIFY;
    end else begin
      return rpp_pkg::RPP_MODE_INHIBIT;
    end
  endfunction : decode_mode

  // Program strobe shares the register clock pin, verify strobe the sync enable pin
  rpp_pkg::rpp_mode_type mode_c;
  assign mode_c = decode_mode(vpp_s, blank_s, cp_s, es_n_s);

  always_comb begin
    st_nxt       = st_r;
    commit       = 1'b0;
    st_nxt.clk_d = cp_s;
    st_nxt.mode  = mode_c;
    st_nxt.pulse_cnt = '0;
    case (mode_c)
      rpp_pkg::RPP_MODE_READ: begin
        if (cp_s && !st_r.clk_d) begin
          st_nxt.outreg     = cell_data_r[a_s];
          st_nxt.outreg_unk = !cell_prog_r[a_s];
          st_nxt.outen      = !es_n_s;
        end
        st_nxt.dout  = st_r.outreg;
        st_nxt.doe_n = {DATA_W{!(st_r.outen && !e_n_s)}};
        st_nxt.unk   = st_r.outreg_unk;
      end
      rpp_pkg::RPP_MODE_PROGRAM: begin
        // Pulses shorter than the minimum width leave the cell untouched;
        // a pulse of exactly that width commits on its last cycle
        if (st_r.pulse_cnt < CNT_W'(LAST_PULSE)) begin
          st_nxt.pulse_cnt = st_r.pulse_cnt + CNT_W'(1);
        end else begin
          st_nxt.pulse_cnt = st_r.pulse_cnt;
          commit           = 1'b1;
        end
        st_nxt.doe_n = {DATA_W{1'b1}};
        st_nxt.unk   = 1'b0;
      end
      rpp_pkg::RPP_MODE_VERIFY: begin
        st_nxt.dout  = cell_data_r[a_s];
        st_nxt.doe_n = '0;
        st_nxt.unk   = !cell_prog_r[a_s];
      end
      rpp_pkg::RPP_MODE_BLANK1: begin
        st_nxt.dout  = cell_prog_r[a_s] ? cell_data_r[a_s] : rpp_pkg::ALL_ONES;
        st_nxt.doe_n = '0;
        st_nxt.unk   = 1'b0;
      end
      rpp_pkg::RPP_MODE_BLANK0: begin
        st_nxt.dout  = cell_prog_r[a_s] ? cell_data_r[a_s] : rpp_pkg::ALL_ZEROS;
        st_nxt.doe_n = '0;
        st_nxt.unk   = 1'b0;
      end
      default: begin
        st_nxt.outen = 1'b0;
        st_nxt.doe_n = {DATA_W{1'b1}};
        st_nxt.unk   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.doe_n <= {DATA_W{1'b1}};
      st_r.mode  <= rpp_pkg::RPP_MODE_READ;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array data has no reset; only the written flags matter while a cell is erased
  always_ff @(posedge ref_clk_i) begin
    if (commit) begin
      cell_data_r[a_s] <= d_s;
    end
  end

  // Reset stands for a fresh part: it erases every byte, so a mid-run reset loses programmed data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cell_prog_r <= '0;
    end else if (commit) begin
      cell_prog_r[a_s] <= 1'b1;
    end
  end

  assign data_o      = st_r.dout;
  assign data_oe_n_o = st_r.doe_n;
  assign unknown_o   = st_r.unk;
  assign mode_o      = st_r.mode;

  // Plain signals for the addressed cell, so the checks below can look back at them
  logic [DATA_W-1:0] cell_rd_c;
  logic              cell_wr_c;
  assign cell_rd_c = cell_data_r[a_s];
  assign cell_wr_c = cell_prog_r[a_s];

  // A rising register clock seen in read mode, then one more cycle still in read mode
  sequence s_read_edge;
    (mode_c == rpp_pkg::RPP_MODE_READ) && cp_s && !st_r.clk_d;
  endsequence

  sequence s_read_hold;
    mode_c == rpp_pkg::RPP_MODE_READ;
  endsequence

  property p_read_loads;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_read_edge ##0 cell_wr_c ##1 s_read_hold |=> (data_o == $past(cell_rd_c, 2));
  endproperty
  a_read_loads: assert property (p_read_loads)
    else $error("read register did not load the addressed byte");

  property p_erased_unknown;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_read_edge ##0 !cell_wr_c ##1 s_read_hold |=> unknown_o;
  endproperty
  a_erased_unknown: assert property (p_erased_unknown)
    else $error("erased byte loaded without the unknown flag");

  property p_inhibit_floats;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_c == rpp_pkg::RPP_MODE_INHIBIT) |=> (data_oe_n_o == {DATA_W{1'b1}}) && !unknown_o;
  endproperty
  a_inhibit_floats: assert property (p_inhibit_floats)
    else $error("outputs driven in program inhibit");

  property p_program_floats;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_c == rpp_pkg::RPP_MODE_PROGRAM) |=> (data_oe_n_o == {DATA_W{1'b1}});
  endproperty
  a_program_floats: assert property (p_program_floats)
    else $error("outputs driven during a program pulse");

  property p_verify_drives;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_c == rpp_pkg::RPP_MODE_VERIFY) && cell_wr_c
        |=> (data_oe_n_o == '0) && (data_o == $past(cell_rd_c)) && !unknown_o;
  endproperty
  a_verify_drives: assert property (p_verify_drives)
    else $error("verify did not drive the written byte");

  property p_blank_ones;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_c == rpp_pkg::RPP_MODE_BLANK1) && !cell_wr_c |=> (data_oe_n_o == '0) && (data_o == rpp_pkg::ALL_ONES);
  endproperty
  a_blank_ones: assert property (p_blank_ones)
    else $error("erased byte not read as all ones in blank check");

  property p_blank_zeros;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_c == rpp_pkg::RPP_MODE_BLANK0) && !cell_wr_c |=> (data_oe_n_o == '0) && (data_o == rpp_pkg::ALL_ZEROS);
  endproperty
  a_blank_zeros: assert property (p_blank_zeros)
    else $error("erased byte not read as all zeros in blank check");
endmodule : rpp_prom
`default_nettype wire

// file: verification/rpp_prog.sv
// Programmer model that drives the PROM pins and paces every step
`default_nettype none
module rpp_prog (
  input  wire logic       ref_clk_i,
  output logic      [8:0] addr_o,
  output logic            register_clock_o,
  output logic            sync_output_enable_n_o,
  output logic            supervoltage_o,
  output logic            blank_check_o,
  output logic      [7:0] data_o,
  output logic            look_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {addr_o, register_clock_o, sync_output_enable_n_o} = '0;
    {supervoltage_o, blank_check_o, data_o, look_o} = '0;
  end

  // Eight cycles clears the synchroniser and the output register
  task automatic set_pins(input logic [8:0] a, input logic rc, input logic se);
    addr_o = a;
    register_clock_o = rc;
    sync_output_enable_n_o = se;
    repeat (8) @(negedge ref_clk_i);
  endtask : set_pins

  task automatic look();
    look_o = 1'b1;
    @(negedge ref_clk_i);
    look_o = 1'b0;
  endtask : look

  // Enable level is set up before the rising register clock
  task automatic read(input logic [8:0] a, input logic se);
    set_pins(a, 1'b0, se);
    set_pins(a, 1'b1, se);
  endtask : read

  task automatic enter_program();
    set_pins(9'h000, 1'b1, 1'b1);
    supervoltage_o = 1'b1;
    repeat (8) @(negedge ref_clk_i);
  endtask : enter_program
endmodule : rpp_prog
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the registered PROM core
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  addr;
  logic        rclk, se_n, sv, blank, look, unk;
  logic [7:0]  din, dout, oe_n;
  logic [2:0]  mode;
  logic [19:0] notes[$];
  logic [19:0] exp_v;
  logic [7:0]  seed = 8'h27;
  logic [8:0]  adr[4];
  logic [7:0]  dat[4];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          low_cyc;
  logic        ok;
  localparam int MAX_TRIES = 4;

  always #5 ref_clk = ~ref_clk;

  rpp_prog rpp_prog_i (.ref_clk_i(ref_clk), .addr_o(addr), .register_clock_o(rclk),
    .sync_output_enable_n_o(se_n), .supervoltage_o(sv), .blank_check_o(blank), .data_o(din), .look_o(look));
  rpp_prom rpp_prom_i (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr), .register_clock_i(rclk),
    .sync_output_enable_n_i(se_n), .async_output_enable_n_i(1'b0), .supervoltage_i(sv),
    .blank_check_i(blank), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n), .unknown_o(unk), .mode_o(mode));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [2:0] m, input logic u, input logic [7:0] oe, input logic [7:0] d);
    notes.push_back({m, u, oe, d});
    rpp_prog_i.look();
  endtask : chk

  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Data is only compared while the outputs are driven and the unknown flag is clear
  always @(posedge ref_clk) begin
    if (look === 1'b1) begin
      exp_v = notes.pop_front();
      samples_checked++;
      if (mode !== exp_v[19:17] || unk !== exp_v[16] || oe_n !== exp_v[15:8]
          || (exp_v[16:8] == 9'h000 && dout !== exp_v[7:0])) begin
        n_errors++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp_v, {mode, unk, oe_n, dout});
      end
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rpp_prog_i.blank_check_o = 1'b1;
    for (int k = 0; k < 1024; k++) begin
      rpp_prog_i.set_pins(k[8:0], 1'b0, k[9]);
      chk(k[9] ? rpp_pkg::RPP_MODE_BLANK0 : rpp_pkg::RPP_MODE_BLANK1, 1'b0, 8'h00, k[9] ? 8'h00 : 8'hff);
    end
    rpp_prog_i.blank_check_o = 1'b0;
    rpp_prog_i.read(9'h1ff, 1'b0);
    chk(rpp_pkg::RPP_MODE_READ, 1'b1, 8'h00, 8'h00);
    rpp_prog_i.read(9'h1ff, 1'b1);
    // The unknown flag follows the register even while the outputs float
    chk(rpp_pkg::RPP_MODE_READ, 1'b1, 8'hff, 8'h00);
    rpp_prog_i.enter_program();
    chk(rpp_pkg::RPP_MODE_INHIBIT, 1'b0, 8'hff, 8'h00);
    // First three bytes get pulses of exactly the minimum width; the fourth gets one cycle
    // short, then short retries, and must be given up. Overprogram and brute-force pulses
    // run far past the cycle budget, so only the short-pulse loop is exercised.
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      adr[i] = {seed[6:0], i[1:0]};
      seed = lfsr(seed);
      dat[i] = seed;
      rpp_prog_i.data_o = dat[i];
      ok = 1'b0;
      for (int att = 0; att < MAX_TRIES && !ok; att++) begin
        rpp_prog_i.set_pins(adr[i], 1'b1, 1'b1);
        rpp_prog_i.set_pins(adr[i], 1'b0, 1'b1);
        chk(rpp_pkg::RPP_MODE_PROGRAM, 1'b0, 8'hff, 8'h00);
        // Nine cycles of the pulse are already spent in the two calls above
        low_cyc = (i < 3) ? rpp_pkg::MIN_PULSE_CYC - 9 : ((att == 0) ? rpp_pkg::MIN_PULSE_CYC - 10 : 50);
        repeat (low_cyc) @(negedge ref_clk);
        rpp_prog_i.set_pins(adr[i], 1'b1, 1'b0);
        chk(rpp_pkg::RPP_MODE_VERIFY, i == 3, 8'h00, dat[i]);
        ok = (unk === 1'b0) && (dout === dat[i]);
      end
      rpp_prog_i.set_pins(adr[i], 1'b1, 1'b1);
      samples_checked++;
      if (ok !== (i < 3)) begin
        n_errors++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, i < 3, ok);
      end
    end
    rpp_prog_i.supervoltage_o = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rpp_prog_i.read(adr[i], 1'b0);
      chk(rpp_pkg::RPP_MODE_READ, i == 3, 8'h00, dat[i]);
    end
    test_done();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule : tb
`default_nettype wire
